// ### verilog/cfr_pkg.sv
// constants, enumerations and carrier structs for the card file record access block
// assumes a single clock domain shared with the command source
package cfr_pkg;
	localparam int NFILE = 8;
	localparam int FIW   = 3;
	localparam int MEMW  = 9;
	localparam int MEMD  = 512;
	localparam int AIDB  = 16;

	localparam logic [FIW-1:0] ROOT_IDX    = 3'h0;
	localparam logic [15:0]    FID_ROOT    = 16'h3F00;
	localparam logic [15:0]    FID_CUR_APP = 16'h7FFF;
	localparam logic [15:0]    FID_TELECOM = 16'h7F10;
	localparam logic [15:0]    BIN_FIRST   = 16'h0000;
	localparam logic [7:0]     REC_FIRST   = 8'h01;
	localparam logic [7:0]     REC_MAX_CNT = 8'hFE;
	localparam logic [7:0]     CYC_MAX_LEN = 8'hFE;
	localparam logic [4:0]     SFI_MIN     = 5'h01;
	localparam logic [4:0]     SFI_MAX     = 5'h1E;
	localparam logic [4:0]     AID_MAX_LEN = 5'h10;

	typedef enum logic [1:0] {FT_DIR = 2'h0, FT_BIN = 2'h1, FT_LIN = 2'h2, FT_CYC = 2'h3} cfr_ftype_t;
	typedef enum logic [3:0] {
		OP_NOP = 4'h0, OP_CREATE = 4'h1, OP_SEL_FID = 4'h2, OP_SEL_PATH = 4'h3, OP_SEL_AID = 4'h4,
		OP_RD_BIN = 4'h5, OP_UPD_BIN = 4'h6, OP_RD_REC = 4'h7, OP_UPD_REC = 4'h8, OP_SEARCH = 4'h9
	} cfr_op_t;
	typedef enum logic [1:0] {RM_NEXT = 2'h0, RM_PREV = 2'h1, RM_CURR = 2'h2, RM_ABS = 2'h3} cfr_rmode_t;
	typedef enum logic [3:0] {
		ST_OK = 4'h0, ST_NOT_FOUND = 4'h1, ST_BAD_PARAM = 4'h2, ST_CONFLICT = 4'h3, ST_WRONG_TYPE = 4'h4,
		ST_OUT_RANGE = 4'h5, ST_NO_RECORD = 4'h6, ST_NO_CURRENT = 4'h7, ST_FULL = 4'h8
	} cfr_stat_t;
	typedef enum logic [2:0] {S_IDLE = 3'b001, S_XFER = 3'b010, S_SRCH = 3'b100} cfr_state_t;

	typedef struct packed {
		logic            valid;
		logic [15:0]     file_identifier;
		cfr_ftype_t      ftype;
		logic [FIW-1:0]  parent;
		logic            sfi_en;
		logic [4:0]      short_file_identifier;
		logic [7:0]      rec_len;
		logic [7:0]      rec_cnt;
		logic [15:0]     size;
		logic [MEMW-1:0] base;
		logic [7:0]      head;
		logic [4:0]      aid_len;
		logic [8*AIDB-1:0] application_identifier;
	} cfr_entry_t;

	localparam cfr_entry_t ROOT_ENTRY = '{valid: 1'b1, file_identifier: FID_ROOT, ftype: FT_DIR, default: '0};

	typedef struct packed {
		logic            valid;
		cfr_op_t         op;
		logic [15:0]     file_identifier;
		logic            path_first;
		logic            path_root;
		logic            use_sfi;
		logic [4:0]      short_file_identifier;
		logic            sfi_en;
		cfr_ftype_t      ftype;
		logic [7:0]      rec_len;
		logic [7:0]      rec_cnt;
		logic [15:0]     size;
		logic [MEMW-1:0] base;
		logic [4:0]      aid_len;
		logic [8*AIDB-1:0] application_identifier;
		cfr_rmode_t      rec_mode;
		logic [7:0]      rec_num;
		logic [15:0]     offset;
		logic [7:0]      count;
		logic [7:0]      data;
	} cfr_req_t;

	typedef struct packed {
		logic        valid;
		logic        last;
		cfr_stat_t   status;
		logic [7:0]  data;
		logic [15:0] size;
		logic [7:0]  rec_len;
		logic [15:0] total;
	} cfr_rsp_t;
endpackage

// ### verilog/cfr_file_access.sv
// card file store: directory tree, selection, byte-stream and record access
// assumes requests come from logic on mclk_i and are held only for the cycle they are offered
// Contract
// - byte files start at offset zero, offset plus count
// - selecting byte file reports its data length
// - fixed records numbered from one, report length, total
// - unset pointer: next gives first, previous gives last
// - set pointer: refuse next at last, previous at first
// - record chosen by absolute number or pattern search
// - failed record operation keeps earlier pointer
// - fixed files: at most 254 records of 255 bytes
// - circular files: at most 254 records of 254 bytes
// - circular pointer wraps between record n and one
// - full circular file overwrites its oldest record
// - newest circular data is record one, oldest n
// - circular writes only in previous mode
// - circular reads: next, previous, current, absolute
// - every file carries a two-byte identifier from creation
// - identifiers unique among siblings and neighbouring directories
// - path runs from root or current, parent to child
// - short identifier is 1 to 30, unique per parent
// - application name 1 to 16 bytes, card unique
// - identifier 7FFF means the active application directory
// - after reset root is current, nothing else selected
// - telecom directory only under root as 7F10
// - directory selection clears current data file
// - record command with short identifier selects, resets pointer
`timescale 1ns/1ps
module cfr_file_access (
	input  wire logic                    mclk_i,
	input  wire logic                    rst_i,
	input  wire cfr_pkg::cfr_req_t       req_i,
	output logic                         busy_o,
	output cfr_pkg::cfr_rsp_t            rsp_o,
	output logic [cfr_pkg::FIW-1:0]      cur_dir_o,
	output logic [cfr_pkg::FIW-1:0]      cur_ef_o,
	output logic                         ef_sel_o
);
	import cfr_pkg::*;

	cfr_entry_t        tab_q [NFILE];
	logic [7:0]        mem_q [MEMD];
	cfr_state_t        state_q;
	logic              busy_q;
	logic [FIW-1:0]    cur_dir_q, cur_ef_q, app_q, path_q;
	logic              ef_set_q, app_set_q, ptr_set_q;
	logic [7:0]        ptr_q, left_q, srch_rec_q, pat_q;
	logic [15:0]       off_q;
	logic [MEMW-1:0]   addr_q;
	cfr_rsp_t          rsp_q;

	logic              idle, take;
	logic [FIW-1:0]    cur_par, path_base, f_idx, free_idx;
	logic [NFILE-1:0]  fid_eq, sel_hit, path_hit, aid_hit, fid_cf, sfi_cf, sfi_hit, free_v;
	logic [8*AIDB-1:0] aid_mask;
	cfr_entry_t        fe, new_ent, se;
	logic              f_ok, is_rec, cyc, pset, next_ok, prev_ok, abs_ok, rec_ok, is_upd;
	logic [7:0]        n, p_next, p_prev, rec_sel, rec_cur, log_slot, head_dn, slot, eff_cnt;
	logic [8:0]        slot_sum;
	logic [15:0]       byte_off;
	logic [16:0]       end_pos;
	logic              rec_rng, bin_rng, crt_bad, srch_hit;
	logic [MEMW-1:0]   rec_addr, bin_addr;
	cfr_stat_t         x_st;
	logic              x_sel, x_new, x_xfer, x_srch, x_wr, x_ptr, x_push;
	logic [FIW-1:0]    x_sidx;
	logic [MEMW-1:0]   x_addr;

	function automatic logic [FIW-1:0] first_idx(input logic [NFILE-1:0] v);
		logic [FIW-1:0] r;
		r = '0;
		for (int i = NFILE-1; i >= 0; i--) begin
			if (v[i]) r = FIW'(i);
		end
		return r;
	endfunction

	assign idle      = state_q == S_IDLE;
	assign take      = req_i.valid && idle;
	assign cur_par   = tab_q[cur_dir_q].parent;
	// path walks parent to child from root, current directory, or last step
	assign path_base = req_i.path_first ? (req_i.path_root ? ROOT_IDX : cur_dir_q) : path_q;
	assign free_idx  = first_idx(free_v);

	for (genvar b = 0; b < AIDB; b++) begin : g_aid
		assign aid_mask[8*b +: 8] = {8{5'(b) < req_i.aid_len}};
	end

	for (genvar g = 0; g < NFILE; g++) begin : g_ent
		localparam logic [FIW-1:0] IX = FIW'(g);
		cfr_entry_t e;
		assign e           = tab_q[g];
		assign fid_eq[g]   = e.valid && e.file_identifier == req_i.file_identifier;
		assign sel_hit[g]  = fid_eq[g] && (IX == cur_dir_q || IX == ROOT_IDX || IX == cur_par ||
			(IX != ROOT_IDX && (e.parent == cur_dir_q || (e.ftype == FT_DIR && e.parent == cur_par))));
		assign path_hit[g] = fid_eq[g] && IX != ROOT_IDX && e.parent == path_base;
		assign aid_hit[g]  = e.valid && e.ftype == FT_DIR && e.aid_len != 5'h00 && e.aid_len == req_i.aid_len &&
			((e.application_identifier ^ req_i.application_identifier) & aid_mask) == '0;
		assign fid_cf[g]   = fid_eq[g] && (e.parent == cur_dir_q || IX == cur_dir_q || IX == cur_par ||
			e.parent == cur_par);
		assign sfi_cf[g]   = e.valid && e.sfi_en && e.short_file_identifier == req_i.short_file_identifier && e.parent == cur_dir_q && IX != ROOT_IDX;
		assign sfi_hit[g]  = sfi_cf[g] && e.ftype != FT_DIR;
		assign free_v[g]   = !e.valid;

		always_ff @(posedge mclk_i or posedge rst_i) begin
			if (rst_i) begin
				tab_q[g] <= (IX == ROOT_IDX) ? ROOT_ENTRY : '0;
			end else if (take && x_new && free_idx == IX) begin
				tab_q[g] <= new_ent;
			end else if (take && x_push && f_idx == IX) begin
				tab_q[g].head <= head_dn;
			end
		end
	end

	assign new_ent = '{valid: 1'b1, file_identifier: req_i.file_identifier, ftype: req_i.ftype, parent: cur_dir_q, sfi_en: req_i.sfi_en,
		short_file_identifier: req_i.short_file_identifier, rec_len: req_i.rec_len, rec_cnt: req_i.rec_cnt, size: req_i.size, base: req_i.base,
		head: 8'h00, aid_len: req_i.aid_len, application_identifier: req_i.application_identifier & aid_mask};

	// creation limits: record counts, lengths, short identifiers, names, telecom placement
	assign crt_bad = (req_i.sfi_en && (req_i.short_file_identifier < SFI_MIN || req_i.short_file_identifier > SFI_MAX)) ||
		(req_i.file_identifier == FID_TELECOM && (req_i.ftype != FT_DIR || cur_dir_q != ROOT_IDX)) ||
		((req_i.ftype == FT_LIN || req_i.ftype == FT_CYC) && (req_i.rec_cnt == 8'h00 ||
		req_i.rec_cnt > REC_MAX_CNT || req_i.rec_len == 8'h00)) ||
		(req_i.ftype == FT_CYC && req_i.rec_len > CYC_MAX_LEN) ||
		(req_i.ftype == FT_DIR && req_i.aid_len > AID_MAX_LEN);

	// short identifier picks a child data file of the current directory
	assign f_idx   = (idle && req_i.use_sfi) ? first_idx(sfi_hit) : cur_ef_q;
	assign f_ok    = req_i.use_sfi ? |sfi_hit : ef_set_q;
	assign fe      = tab_q[f_idx];
	assign n       = fe.rec_cnt;
	assign cyc     = fe.ftype == FT_CYC;
	assign is_rec  = fe.ftype == FT_LIN || cyc;
	assign is_upd  = req_i.op == OP_UPD_REC || req_i.op == OP_UPD_BIN;
	assign pset    = ptr_set_q && !req_i.use_sfi;
	assign p_next  = (!pset || ptr_q == n) ? REC_FIRST : ptr_q + REC_FIRST;
	assign p_prev  = (!pset || ptr_q == REC_FIRST) ? n : ptr_q - REC_FIRST;
	assign next_ok = !pset || cyc || ptr_q != n;
	assign prev_ok = !pset || cyc || ptr_q != REC_FIRST;
	assign abs_ok  = req_i.rec_num != 8'h00 && req_i.rec_num <= n;
	assign rec_sel = req_i.rec_mode == RM_NEXT ? p_next : req_i.rec_mode == RM_PREV ? p_prev :
		req_i.rec_mode == RM_CURR ? ptr_q : req_i.rec_num;
	assign rec_ok  = req_i.rec_mode == RM_NEXT ? next_ok : req_i.rec_mode == RM_PREV ? prev_ok :
		req_i.rec_mode == RM_CURR ? pset : abs_ok;
	assign rec_cur = (state_q == S_SRCH) ? srch_rec_q : rec_sel;
	// logical record one sits at the head slot, so the newest circular data always reads as record one
	assign slot_sum = {1'b0, fe.head} + {1'b0, rec_cur} - 9'h001;
	assign log_slot = (slot_sum >= {1'b0, n}) ? 8'(slot_sum - {1'b0, n}) : 8'(slot_sum);
	assign head_dn  = (fe.head == 8'h00) ? n - REC_FIRST : fe.head - REC_FIRST;
	assign slot     = (cyc && req_i.op == OP_UPD_REC && idle) ? head_dn : log_slot;
	assign byte_off = idle ? req_i.offset : off_q;
	assign rec_addr = fe.base + MEMW'({8'h00, slot} * {8'h00, fe.rec_len}) + MEMW'(byte_off);
	assign bin_addr = fe.base + MEMW'(req_i.offset - BIN_FIRST);
	assign eff_cnt  = (is_upd || req_i.op == OP_SEARCH) ? 8'h01 : req_i.count;
	assign end_pos  = {1'b0, req_i.offset} + {9'h000, eff_cnt};
	assign rec_rng  = eff_cnt != 8'h00 && end_pos <= {9'h000, fe.rec_len};
	assign bin_rng  = eff_cnt != 8'h00 && end_pos <= {1'b0, fe.size};
	assign srch_hit = mem_q[rec_addr] == pat_q;

	always_comb begin
		x_st   = ST_OK;
		x_sel  = 1'b0;
		x_new  = 1'b0;
		x_xfer = 1'b0;
		x_srch = 1'b0;
		x_wr   = 1'b0;
		x_ptr  = 1'b0;
		x_push = 1'b0;
		x_sidx = first_idx(sel_hit);
		x_addr = bin_addr;
		case (req_i.op)
			OP_CREATE: begin
				if (!(|free_v)) x_st = ST_FULL;
				else if (|fid_cf || req_i.file_identifier == FID_CUR_APP || req_i.file_identifier == FID_ROOT ||
					(req_i.sfi_en && |sfi_cf) || (req_i.aid_len != 5'h00 && |aid_hit)) x_st = ST_CONFLICT;
				else if (crt_bad) x_st = ST_BAD_PARAM;
				else x_new = 1'b1;
			end
			OP_SEL_FID, OP_SEL_PATH: begin
				if (req_i.file_identifier == FID_CUR_APP && (req_i.op == OP_SEL_FID || (req_i.path_first && req_i.path_root))) begin
					x_sidx = app_q;
					x_sel  = app_set_q;
				end else if (req_i.op == OP_SEL_PATH) begin
					x_sidx = first_idx(path_hit);
					x_sel  = |path_hit;
				end else begin
					x_sel  = |sel_hit;
				end
				if (!x_sel) x_st = ST_NOT_FOUND;
			end
			OP_SEL_AID: begin
				x_sidx = first_idx(aid_hit);
				x_sel  = |aid_hit;
				if (!x_sel) x_st = ST_NOT_FOUND;
			end
			OP_RD_BIN, OP_UPD_BIN: begin
				if (!f_ok) x_st = ST_NO_CURRENT;
				else if (fe.ftype != FT_BIN) x_st = ST_WRONG_TYPE;
				else if (!bin_rng) x_st = ST_OUT_RANGE;
				else if (is_upd) x_wr = 1'b1;
				else x_xfer = 1'b1;
			end
			OP_RD_REC, OP_UPD_REC, OP_SEARCH: begin
				x_addr = rec_addr;
				if (!f_ok) x_st = ST_NO_CURRENT;
				else if (!is_rec) x_st = ST_WRONG_TYPE;
				else if (cyc && req_i.op == OP_UPD_REC && req_i.rec_mode != RM_PREV) x_st = ST_BAD_PARAM;
				else if (!rec_rng) x_st = ST_OUT_RANGE;
				else if (req_i.op == OP_SEARCH) x_srch = 1'b1;
				else if (!rec_ok) x_st = ST_NO_RECORD;
				else begin
					x_ptr  = 1'b1;
					x_xfer = !is_upd;
					x_wr   = is_upd;
					x_push = is_upd && cyc;
				end
			end
			default: x_st = ST_BAD_PARAM;
		endcase
	end

	assign se = tab_q[x_sidx];

	always_ff @(posedge mclk_i) begin
		if (take && x_wr) mem_q[x_addr] <= req_i.data;
	end

	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			state_q    <= S_IDLE;
			busy_q     <= 1'b0;
			cur_dir_q  <= ROOT_IDX;
			cur_ef_q   <= ROOT_IDX;
			ef_set_q   <= 1'b0;
			app_q      <= ROOT_IDX;
			app_set_q  <= 1'b0;
			path_q     <= ROOT_IDX;
			ptr_q      <= 8'h00;
			ptr_set_q  <= 1'b0;
			left_q     <= 8'h00;
			srch_rec_q <= 8'h00;
			pat_q      <= 8'h00;
			off_q      <= 16'h0000;
			addr_q     <= '0;
			rsp_q      <= '0;
		end else begin
			rsp_q <= '0;
			case (state_q)
				S_IDLE: begin
					if (take) begin
						rsp_q.valid  <= !(x_xfer || x_srch);
						rsp_q.last   <= !(x_xfer || x_srch);
						rsp_q.status <= x_st;
						if (x_sel) begin
							if (se.ftype == FT_DIR) begin
								cur_dir_q <= x_sidx;
								path_q    <= x_sidx;
								ef_set_q  <= 1'b0;
							end else begin
								cur_dir_q <= se.parent;
								cur_ef_q  <= x_sidx;
								ef_set_q  <= 1'b1;
							end
							ptr_set_q     <= 1'b0;
							rsp_q.size    <= (se.ftype == FT_BIN) ? se.size : 16'h0000;
							rsp_q.rec_len <= (se.ftype == FT_DIR || se.ftype == FT_BIN) ? 8'h00 : se.rec_len;
							rsp_q.total   <= (se.ftype == FT_DIR || se.ftype == FT_BIN) ? 16'h0000 :
								{8'h00, se.rec_len} * {8'h00, se.rec_cnt};
							if (req_i.op == OP_SEL_AID) begin
								app_q     <= x_sidx;
								app_set_q <= 1'b1;
							end
						end
						if (req_i.use_sfi && f_ok && req_i.op >= OP_RD_BIN) begin
							cur_dir_q <= fe.parent;
							cur_ef_q  <= f_idx;
							ef_set_q  <= 1'b1;
							ptr_set_q <= 1'b0;
						end
						if (x_ptr) begin
							ptr_q     <= x_push ? REC_FIRST : rec_sel;
							ptr_set_q <= 1'b1;
						end
						if (x_xfer) begin
							state_q <= S_XFER;
							busy_q  <= 1'b1;
							addr_q  <= x_addr;
							left_q  <= req_i.count;
						end
						if (x_srch) begin
							state_q    <= S_SRCH;
							busy_q     <= 1'b1;
							srch_rec_q <= REC_FIRST;
							pat_q      <= req_i.data;
							off_q      <= req_i.offset;
						end
					end
				end
				S_XFER: begin
					rsp_q.valid <= 1'b1;
					rsp_q.data  <= mem_q[addr_q];
					rsp_q.last  <= left_q == 8'h01;
					addr_q      <= addr_q + MEMW'(1);
					left_q      <= left_q - 8'h01;
					if (left_q == 8'h01) begin
						state_q <= S_IDLE;
						busy_q  <= 1'b0;
					end
				end
				S_SRCH: begin
					if (srch_hit || srch_rec_q == n) begin
						rsp_q.valid  <= 1'b1;
						rsp_q.last   <= 1'b1;
						rsp_q.status <= srch_hit ? ST_OK : ST_NOT_FOUND;
						rsp_q.data   <= srch_hit ? srch_rec_q : 8'h00;
						state_q      <= S_IDLE;
						busy_q       <= 1'b0;
						if (srch_hit) begin
							ptr_q     <= srch_rec_q;
							ptr_set_q <= 1'b1;
						end
					end else begin
						srch_rec_q <= srch_rec_q + REC_FIRST;
					end
				end
				default: begin
					state_q <= S_IDLE;
					busy_q  <= 1'b0;
				end
			endcase
		end
	end

	assign busy_o    = busy_q;
	assign rsp_o     = rsp_q;
	assign cur_dir_o = cur_dir_q;
	assign cur_ef_o  = cur_ef_q;
	assign ef_sel_o  = ef_set_q;
endmodule

// ### tb/cfr_file_access_sva.sv
// port assertions for the card file store
// assumes one clock domain and an asynchronous active-high reset
`timescale 1ns/1ps
module cfr_file_access_sva (
	input wire logic                  mclk_i,
	input wire logic                  rst_i,
	input wire cfr_pkg::cfr_req_t     req_i,
	input wire logic                  busy_o,
	input wire cfr_pkg::cfr_rsp_t     rsp_o,
	input wire logic [cfr_pkg::FIW-1:0] cur_dir_o,
	input wire logic [cfr_pkg::FIW-1:0] cur_ef_o,
	input wire logic                  ef_sel_o
);
	import cfr_pkg::*;
	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (rst_i);
	sequence s_take(cfr_op_t o);
		req_i.valid && !busy_o && req_i.op == o;
	endsequence
	sequence s_fail;
		rsp_o.valid && rsp_o.last && rsp_o.status != ST_OK;
	endsequence
	root_at_start_a: assert property ($fell(rst_i) |-> cur_dir_o == ROOT_IDX && !ef_sel_o)
		else $error("current directory not root after reset");
	sfi_range_a: assert property (s_take(OP_CREATE) ##0 (req_i.sfi_en && req_i.short_file_identifier inside {5'h00, 5'h1F}) |=> s_fail)
		else $error("short identifier out of range accepted");
	aid_len_a: assert property (s_take(OP_CREATE) ##0 (req_i.aid_len > AID_MAX_LEN) |=> s_fail)
		else $error("application name too long accepted");
	app_fid_a: assert property (s_take(OP_CREATE) ##0 (req_i.file_identifier == FID_CUR_APP) |=> s_fail)
		else $error("reserved identifier accepted at creation");
	lin_count_a: assert property (s_take(OP_CREATE) ##0 (req_i.ftype == FT_LIN && (req_i.rec_cnt == 8'h00
		|| req_i.rec_cnt > REC_MAX_CNT)) |=> s_fail)
		else $error("record count out of range accepted");
	cyc_len_a: assert property (s_take(OP_CREATE) ##0 (req_i.ftype == FT_CYC && req_i.rec_len > CYC_MAX_LEN) |=> s_fail)
		else $error("circular record length out of range accepted");
	abs_zero_a: assert property (s_take(OP_RD_REC) ##0 (req_i.rec_mode == RM_ABS && req_i.rec_num == 8'h00)
		|=> s_fail)
		else $error("record number zero accepted");
	fail_keeps_a: assert property ((req_i.valid && !busy_o && !req_i.use_sfi) ##1 s_fail |->
		cur_dir_o == $past(cur_dir_o) && ef_sel_o == $past(ef_sel_o) && cur_ef_o == $past(cur_ef_o))
		else $error("failed command changed the selection");
	dir_clear_a: assert property ((req_i.valid && !busy_o && req_i.op inside {OP_SEL_FID, OP_SEL_PATH, OP_SEL_AID})
		##1 (rsp_o.valid && rsp_o.status == ST_OK && rsp_o.size == 16'h0000 && rsp_o.total == 16'h0000) |-> !ef_sel_o)
		else $error("directory selection kept a data file");
	bin_sel_a: assert property (s_take(OP_SEL_FID) ##1 (rsp_o.valid && rsp_o.status == ST_OK
		&& rsp_o.size != 16'h0000) |-> ef_sel_o)
		else $error("byte file selection left no data file");
	read_lat_a: assert property (s_take(OP_RD_BIN) ##1 !rsp_o.valid |-> busy_o ##1 rsp_o.valid)
		else $error("byte read stream timing wrong");
endmodule
bind cfr_file_access cfr_file_access_sva u_cfr_file_access_sva (.mclk_i(mclk_i), .rst_i(rst_i), .req_i(req_i),
	.busy_o(busy_o), .rsp_o(rsp_o), .cur_dir_o(cur_dir_o), .cur_ef_o(cur_ef_o), .ef_sel_o(ef_sel_o));

// ### tb/cfr_term.sv
// terminal side model: offers one command at a time and gathers its answer beats
// assumes the file store answers within 300 cycles of mclk_i
`timescale 1ns/1ps
module cfr_term (
	input  wire logic              mclk_i,
	input  wire logic              busy_i,
	input  wire cfr_pkg::cfr_rsp_t rsp_i,
	output cfr_pkg::cfr_req_t      req_o
);
	import cfr_pkg::*;
	cfr_rsp_t rq[$];
	initial begin
		req_o = '0;
	end
	always @(posedge mclk_i) begin
		if (rsp_i.valid) begin
			rq.push_back(rsp_i);
		end
	end
	// one command in flight; fields are scrambled while valid is low
	task automatic xfer(input cfr_req_t r);
		cfr_req_t idle;
		int       n;
		idle = ~r;
		idle.valid = 1'b0;
		rq.delete();
		n = 0;
		while (busy_i !== 1'b0 && n < 300) begin
			@(posedge mclk_i);
			n++;
		end
		@(posedge mclk_i);
		req_o <= r;
		@(posedge mclk_i);
		req_o <= idle;
		n = 0;
		while (!(rq.size() > 0 && rq[$].last === 1'b1) && n < 300) begin
			@(posedge mclk_i);
			#1;
			n++;
		end
	endtask
endmodule

// ### tb/tb_card_file_record_access.sv
// self-checking bench for the card file store
// assumes the terminal model cfr_term and the package cfr_pkg
`timescale 1ns/1ps
module tb_card_file_record_access;
	import cfr_pkg::*;
	logic           mclk_i = 1'b0;
	logic           rst_i = 1'b1;
	cfr_req_t       req;
	logic           busy;
	cfr_rsp_t       rsp;
	logic [FIW-1:0] cur_dir;
	logic [FIW-1:0] cur_ef;
	logic           ef_sel;
	int             mismatches = 0;
	int             compares = 0;
	int             cycles = 0;
	always #50 mclk_i = ~mclk_i;
	cfr_file_access u_cfr_file_access (.mclk_i(mclk_i), .rst_i(rst_i), .req_i(req), .busy_o(busy), .rsp_o(rsp),
		.cur_dir_o(cur_dir), .cur_ef_o(cur_ef), .ef_sel_o(ef_sel));
	cfr_term u_cfr_term (.mclk_i(mclk_i), .busy_i(busy), .rsp_i(rsp), .req_o(req));
	task automatic stop_test();
		$display("compares %0d mismatches %0d", compares, mismatches);
		if (mismatches == 0 && compares > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	always @(posedge mclk_i) begin
		cycles++;
		if (cycles == 5000) begin
			mismatches++;
			stop_test();
		end
	end
	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			mismatches++;
			$display("mismatch %s expected %h seen %h", name, exp, seen);
		end
	endtask
	function automatic cfr_req_t rq(cfr_op_t op, logic [15:0] file_identifier, cfr_rmode_t m, logic [7:0] n, logic [7:0] d,
		logic [15:0] off);
		cfr_req_t r;
		r = '0;
		r.valid = 1'b1;
		r.op = op;
		r.file_identifier = file_identifier;
		r.rec_mode = m;
		r.rec_num = n;
		r.data = d;
		r.offset = off;
		r.count = 8'h01;
		return r;
	endfunction
	function automatic cfr_req_t cr(logic [15:0] file_identifier, cfr_ftype_t ft, logic [7:0] len, logic [7:0] cnt,
		logic [15:0] sz, logic [MEMW-1:0] base);
		cfr_req_t r;
		r = rq(OP_CREATE, file_identifier, RM_NEXT, 8'h00, 8'h00, 16'h0000);
		r.ftype = ft;
		r.rec_len = len;
		r.rec_cnt = cnt;
		r.size = sz;
		r.base = base;
		return r;
	endfunction
	task automatic run(input cfr_req_t r, input cfr_stat_t es);
		u_cfr_term.xfer(r);
		check("answered", u_cfr_term.rq.size() != 0, 1'b1);
		check("status", u_cfr_term.rq[0].status, es);
	endtask
	task automatic sel(input logic [15:0] file_identifier);
		run(rq(OP_SEL_FID, file_identifier, RM_NEXT, 8'h00, 8'h00, 16'h0000), ST_OK);
	endtask
	task automatic rd(input cfr_rmode_t m, input logic [7:0] n, input logic [7:0] e);
		run(rq(OP_RD_REC, 16'h0000, m, n, 8'h00, 16'h0000), ST_OK);
		check("record byte", u_cfr_term.rq[0].data, e);
	endtask
	task automatic no_rec(input cfr_rmode_t m);
		u_cfr_term.xfer(rq(OP_RD_REC, 16'h0000, m, 8'h00, 8'h00, 16'h0000));
		check("step refused", u_cfr_term.rq[0].status == ST_OK, 1'b0);
	endtask
	task automatic t_bin();
		cfr_req_t r;
		check("root current", cur_dir, ROOT_IDX);
		check("no data file", ef_sel, 1'b0);
		r = cr(16'h2F00, FT_BIN, 8'h00, 8'h00, 16'h0010, 9'h000);
		run(r, ST_OK);
		run(r, ST_CONFLICT);
		sel(16'h2F00);
		check("size", u_cfr_term.rq[0].size, 16'h0010);
		run(rq(OP_UPD_BIN, 16'h0000, RM_NEXT, 8'h00, 8'h5A, 16'h0000), ST_OK);
		run(rq(OP_UPD_BIN, 16'h0000, RM_NEXT, 8'h00, 8'hA5, 16'h0001), ST_OK);
		r = rq(OP_RD_BIN, 16'h0000, RM_NEXT, 8'h00, 8'h00, 16'h0000);
		r.count = 8'h02;
		run(r, ST_OK);
		check("beats", u_cfr_term.rq.size(), 2);
		check("byte 0", u_cfr_term.rq[0].data, 8'h5A);
		check("byte 1", u_cfr_term.rq[1].data, 8'hA5);
		r.offset = 16'h000F;
		run(r, ST_OUT_RANGE);
		$display("test byte file done");
	endtask
	task automatic t_lin();
		cfr_req_t r;
		r = cr(16'h6F01, FT_LIN, 8'h04, 8'h03, 16'h0000, 9'h040);
		r.sfi_en = 1'b1;
		r.short_file_identifier = 5'h00;
		run(r, ST_BAD_PARAM);
		r.short_file_identifier = 5'h1F;
		run(r, ST_BAD_PARAM);
		r.short_file_identifier = SFI_MIN;
		r.rec_cnt = 8'hFF;
		run(r, ST_BAD_PARAM);
		r.rec_cnt = 8'h03;
		run(r, ST_OK);
		sel(16'h6F01);
		check("record length", u_cfr_term.rq[0].rec_len, 8'h04);
		check("total", u_cfr_term.rq[0].total, 16'h000C);
		for (int i = 1; i <= 3; i++) begin
			run(rq(OP_UPD_REC, 16'h0000, RM_ABS, 8'(i), 8'(i), 16'h0000), ST_OK);
		end
		sel(16'h6F01);
		rd(RM_PREV, 8'h00, 8'h03);
		no_rec(RM_NEXT);
		rd(RM_CURR, 8'h00, 8'h03);
		run(rq(OP_RD_REC, 16'h0000, RM_ABS, 8'h04, 8'h00, 16'h0000), ST_NO_RECORD);
		run(rq(OP_RD_REC, 16'h0000, RM_ABS, 8'h00, 8'h00, 16'h0000), ST_NO_RECORD);
		rd(RM_PREV, 8'h00, 8'h02);
		rd(RM_PREV, 8'h00, 8'h01);
		no_rec(RM_PREV);
		run(rq(OP_SEARCH, 16'h0000, RM_NEXT, 8'h00, 8'h02, 16'h0000), ST_OK);
		check("found record", u_cfr_term.rq[0].data, 8'h02);
		rd(RM_CURR, 8'h00, 8'h02);
		sel(16'h6F01);
		rd(RM_NEXT, 8'h00, 8'h01);
		sel(16'h2F00);
		r = rq(OP_RD_REC, 16'h0000, RM_NEXT, 8'h00, 8'h00, 16'h0000);
		r.use_sfi = 1'b1;
		r.short_file_identifier = SFI_MIN;
		run(r, ST_OK);
		check("sfi record", u_cfr_term.rq[0].data, 8'h01);
		check("sfi file", cur_ef, 3'h2);
		$display("test linear file done");
	endtask
	task automatic t_cyc();
		cfr_req_t r;
		r = cr(16'h6F02, FT_CYC, 8'hFF, 8'h03, 16'h0000, 9'h080);
		run(r, ST_BAD_PARAM);
		r.rec_len = 8'h02;
		run(r, ST_OK);
		sel(16'h6F02);
		for (int i = 1; i <= 4; i++) begin
			run(rq(OP_UPD_REC, 16'h0000, RM_PREV, 8'h00, 8'(8'h11 * i), 16'h0000), ST_OK);
		end
		run(rq(OP_UPD_REC, 16'h0000, RM_NEXT, 8'h00, 8'h55, 16'h0000), ST_BAD_PARAM);
		rd(RM_ABS, 8'h01, 8'h44);
		rd(RM_ABS, 8'h02, 8'h33);
		rd(RM_ABS, 8'h03, 8'h22);
		rd(RM_NEXT, 8'h00, 8'h44);
		rd(RM_PREV, 8'h00, 8'h22);
		rd(RM_CURR, 8'h00, 8'h22);
		$display("test cyclic file done");
	endtask
	task automatic t_dir();
		cfr_req_t r;
		run(cr(FID_TELECOM, FT_DIR, 8'h00, 8'h00, 16'h0000, 9'h000), ST_OK);
		sel(FID_TELECOM);
		check("telecom current", cur_dir, 3'h4);
		check("no data file", ef_sel, 1'b0);
		r = cr(16'h7F20, FT_DIR, 8'h00, 8'h00, 16'h0000, 9'h000);
		r.aid_len = 5'h11;
		run(r, ST_BAD_PARAM);
		r.aid_len = 5'h02;
		r.application_identifier = 128'hB1A0;
		run(r, ST_OK);
		r.file_identifier = FID_CUR_APP;
		run(r, ST_CONFLICT);
		sel(FID_ROOT);
		r = rq(OP_SEL_AID, 16'h0000, RM_NEXT, 8'h00, 8'h00, 16'h0000);
		r.aid_len = 5'h02;
		r.application_identifier = 128'hB1A0;
		run(r, ST_OK);
		check("app current", cur_dir, 3'h5);
		sel(FID_ROOT);
		sel(FID_CUR_APP);
		check("app by 7FFF", cur_dir, 3'h5);
		sel(FID_ROOT);
		r = rq(OP_SEL_PATH, FID_TELECOM, RM_NEXT, 8'h00, 8'h00, 16'h0000);
		r.path_first = 1'b1;
		r.path_root = 1'b1;
		run(r, ST_OK);
		run(rq(OP_SEL_PATH, 16'h7F20, RM_NEXT, 8'h00, 8'h00, 16'h0000), ST_OK);
		check("path end", cur_dir, 3'h5);
		$display("test directories done");
	endtask
	initial begin
		repeat (6) @(posedge mclk_i);
		rst_i <= 1'b0;
		@(posedge mclk_i);
		#1;
		t_bin();
		t_lin();
		t_cyc();
		t_dir();
		stop_test();
	end
endmodule
